// ---- design/gpc_defines.vh ----
`ifndef GPC_DEFINES_VH
`define GPC_DEFINES_VH
`define GPC_OFF_PIN_CONFIG    12'h000
`define GPC_OFF_PULL_SELECT   12'h008
`define GPC_OFF_OUTPUT_LATCH  12'h010
`define GPC_OFF_INPUT_SAMPLE  12'h014
`define GPC_OFF_DRIVE_TYPE    12'h018
`define GPC_OFF_DRIVE_STR     12'h01c
`define GPC_OFF_BIT_CLEAR     12'h020
`define GPC_OFF_BIT_SET       12'h024
`define GPC_OFF_BIT_FLIP      12'h028
`define GPC_OFF_ALT_SEL_LO    12'h040
`define GPC_OFF_ALT_SEL_HI    12'h044
`define GPC_RST_PIN_CONFIG    32'hebff0fff
`define GPC_RST_PULL_SELECT   32'h24005000
`define GPC_RST_ZERO16        16'h0000
`define GPC_RST_ZERO32        32'h00000000
`define GPC_MODE_INPUT        2'b00
`define GPC_MODE_OUTPUT       2'b01
`define GPC_MODE_ALT          2'b10
`define GPC_MODE_ANALOG       2'b11
`define GPC_PULL_NONE         2'b00
`define GPC_PULL_UP           2'b01
`define GPC_PULL_DOWN         2'b10
`define GPC_ALT_MAX           4'h5
`define GPC_NUM_ALT           6
`define GPC_HTRANS_NONSEQ     2'b10
`define GPC_HSIZE_WORD        3'b010
`define GPC_HBURST_SINGLE     3'b000
`endif

// ---- design/gpc_port_a.v ----
// Contract
// R1: Each pin has a 2-bit mode: 00 input, 01 output, 10 alternate function, 11 analog.
// R2: The pin configuration register resets to ebff0fff.
// R3: Each pin has a 2-bit pull field: 00 none, 01 pull-up, 10 pull-down, 11 reserved.
// R4: The pull select register resets to 24005000.
// R5: Output mode drives pins from the output latch, alternate mode from the selected peripheral.
// R6: Pin levels read back in the input sample register and feed the alternate function inputs.
// R7: Drive type 0 is push-pull, 1 open-drain where a high comes only from a pull-up or outside.
// R8: Writing 1 to a bit clear bit forces that latch bit to 0, writing 0 does nothing.
// R9: Inputs may float, pull or be analog; outputs push-pull or open-drain with pulls.
// R10: Only 32-bit single word transfers are accepted on the AHB slave.
// R11: Writing 1 to a bit set bit forces that latch bit to 1, writing 0 does nothing.
// R12: Writing 1 to a bit flip bit inverts that latch bit, writing 0 does nothing.
// R13: Each pin has a 4-bit alternate selector for functions 0 to 5; 6 to 15 are reserved.
// R14: Reserved bits 31:16 read as zero and ignore writes.
`timescale 1ns/1ps
`include "gpc_defines.vh"
module gpc_port_a (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [2:0]  hburst,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire [15:0] padIn,
  output reg  [15:0] padOut,
  output reg  [15:0] padOe,
  output reg  [15:0] padPullUp,
  output reg  [15:0] padPullDown,
  output reg  [15:0] padAnalog,
  output reg  [15:0] padInEnable,
  output reg  [15:0] padDriveHigh,
  input  wire [95:0] altOut,
  input  wire [95:0] altOe,
  output reg  [95:0] altIn
);
  reg  [31:0] pinConfig_reg;
  reg  [31:0] pullSelect_reg;
  reg  [15:0] outputLatch_reg;
  reg  [15:0] driveType_reg;
  reg  [15:0] driveStrength_reg;
  reg  [31:0] altSelLo_reg;
  reg  [31:0] altSelHi_reg;
  reg  [15:0] padSync1_reg;
  reg  [15:0] padSync2_reg;
  reg         wrPend_reg;
  reg  [11:0] wrAddr_reg;
  reg  [15:0] latchNext;
  reg  [31:0] rdataNext;
  wire [15:0] outNext;
  wire [15:0] oeNext;
  wire [15:0] puNext;
  wire [15:0] pdNext;
  wire [15:0] anNext;
  wire [15:0] ieNext;
  wire [95:0] altInNext;
  wire        access  = hsel & hready & (htrans == `GPC_HTRANS_NONSEQ);
  wire        legal   = (hsize == `GPC_HSIZE_WORD) & (hburst == `GPC_HBURST_SINGLE) & (haddr[1:0] == 2'b00); // R10
  wire        badAcc  = access & ~legal; // R10
  wire        rdAcc   = access & legal & ~hwrite;
  wire        wrAcc   = access & legal & hwrite;
  wire [63:0] altSel  = {altSelHi_reg, altSelLo_reg}; // R13
  // Write strobes, one per register
  wire        wrPinCfg = wrPend_reg & (wrAddr_reg == `GPC_OFF_PIN_CONFIG);
  wire        wrPull   = wrPend_reg & (wrAddr_reg == `GPC_OFF_PULL_SELECT);
  wire        wrLatch  = wrPend_reg & (wrAddr_reg == `GPC_OFF_OUTPUT_LATCH);
  wire        wrClear  = wrPend_reg & (wrAddr_reg == `GPC_OFF_BIT_CLEAR);
  wire        wrSet    = wrPend_reg & (wrAddr_reg == `GPC_OFF_BIT_SET);
  wire        wrFlip   = wrPend_reg & (wrAddr_reg == `GPC_OFF_BIT_FLIP);
  wire        wrType   = wrPend_reg & (wrAddr_reg == `GPC_OFF_DRIVE_TYPE);
  wire        wrStr    = wrPend_reg & (wrAddr_reg == `GPC_OFF_DRIVE_STR);
  wire        wrAltLo  = wrPend_reg & (wrAddr_reg == `GPC_OFF_ALT_SEL_LO);
  wire        wrAltHi  = wrPend_reg & (wrAddr_reg == `GPC_OFF_ALT_SEL_HI);
  always @* begin
    latchNext = outputLatch_reg;
    if (wrPend_reg) begin
      case (wrAddr_reg)
        `GPC_OFF_OUTPUT_LATCH: latchNext = hwdata[15:0]; // R14
        `GPC_OFF_BIT_CLEAR:    latchNext = outputLatch_reg & ~hwdata[15:0]; // R8
        `GPC_OFF_BIT_SET:      latchNext = outputLatch_reg | hwdata[15:0]; // R11
        `GPC_OFF_BIT_FLIP:     latchNext = outputLatch_reg ^ hwdata[15:0]; // R12
        default:               latchNext = outputLatch_reg;
      endcase
    end
  end
  always @* begin
    case (haddr)
      `GPC_OFF_PIN_CONFIG:   rdataNext = pinConfig_reg;
      `GPC_OFF_PULL_SELECT:  rdataNext = pullSelect_reg;
      `GPC_OFF_OUTPUT_LATCH: rdataNext = {16'h0000, outputLatch_reg}; // R14
      `GPC_OFF_INPUT_SAMPLE: rdataNext = {16'h0000, padSync2_reg}; // R6
      `GPC_OFF_DRIVE_TYPE:   rdataNext = {16'h0000, driveType_reg};
      `GPC_OFF_ALT_SEL_LO:   rdataNext = altSelLo_reg;
      `GPC_OFF_ALT_SEL_HI:   rdataNext = altSelHi_reg;
      `GPC_OFF_DRIVE_STR:    rdataNext = 32'h00000000;
      `GPC_OFF_BIT_CLEAR:    rdataNext = 32'h00000000;
      `GPC_OFF_BIT_SET:      rdataNext = 32'h00000000;
      `GPC_OFF_BIT_FLIP:     rdataNext = 32'h00000000;
      default:               rdataNext = 32'h00000000;
    endcase
  end

  // One mux per pin
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : pinGen
      gpc_pin_mux gpc_pin_mux_inst (
        .mode       (pinConfig_reg[2*g +: 2]),
        .pull       (pullSelect_reg[2*g +: 2]),
        .sel        (altSel[4*g +: 4]),
        .openDrain  (driveType_reg[g]),
        .latchBit   (outputLatch_reg[g]),
        .altOutBits (altOut[6*g +: 6]),
        .altOeBits  (altOe[6*g +: 6]),
        .padBit     (padSync2_reg[g]),
        .outBit     (outNext[g]),
        .oeBit      (oeNext[g]),
        .puBit      (puNext[g]),
        .pdBit      (pdNext[g]),
        .anBit      (anNext[g]),
        .ieBit      (ieNext[g]),
        .altInBits  (altInNext[6*g +: 6])
      );
    end
  endgenerate

  // Two-flop synchroniser for the pins
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      padSync1_reg <= `GPC_RST_ZERO16;
      padSync2_reg <= `GPC_RST_ZERO16;
    end else begin
      padSync1_reg <= padIn;
      padSync2_reg <= padSync1_reg;
    end
  end

  // Configuration and data registers
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinConfig_reg     <= `GPC_RST_PIN_CONFIG; // R2
      pullSelect_reg    <= `GPC_RST_PULL_SELECT; // R4
      outputLatch_reg   <= `GPC_RST_ZERO16;
      driveType_reg     <= `GPC_RST_ZERO16;
      driveStrength_reg <= `GPC_RST_ZERO16;
      altSelLo_reg      <= `GPC_RST_ZERO32;
      altSelHi_reg      <= `GPC_RST_ZERO32;
      wrPend_reg        <= 1'b0;
      wrAddr_reg        <= 12'h000;
    end else begin
      wrPend_reg      <= wrAcc;
      wrAddr_reg      <= haddr;
      outputLatch_reg <= latchNext;
      if (wrPinCfg) begin
        pinConfig_reg <= hwdata;
      end
      if (wrPull) begin
        pullSelect_reg <= hwdata;
      end
      if (wrType) begin
        driveType_reg <= hwdata[15:0]; // R14
      end
      if (wrStr) begin
        driveStrength_reg <= hwdata[15:0]; // R14
      end
      if (wrAltLo) begin
        altSelLo_reg <= hwdata; // R13
      end
      if (wrAltHi) begin
        altSelHi_reg <= hwdata; // R13
      end
    end
  end

  // Read data, registered in the address phase
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h00000000;
    end else if (rdAcc) begin
      hrdata <= rdataNext; // R6
    end
  end

  // Two-cycle error response, a new illegal transfer restarts it
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hresp     <= 1'b0;
      hreadyout <= 1'b1;
    end else if (badAcc) begin
      hresp     <= 1'b1; // R10
      hreadyout <= 1'b0; // R10
    end else if (hresp && !hreadyout) begin
      hresp     <= 1'b1;
      hreadyout <= 1'b1;
    end else begin
      hresp     <= 1'b0;
      hreadyout <= 1'b1;
    end
  end

  // Pin drive, registered so all pins switch together
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      padOut       <= 16'h0000;
      padOe        <= 16'h0000;
      padDriveHigh <= 16'h0000;
    end else begin
      padOut       <= outNext;
      padOe        <= oeNext;
      padDriveHigh <= driveStrength_reg;
    end
  end

  // Pulls and input buffers
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      padPullUp   <= 16'h0000;
      padPullDown <= 16'h0000;
      padAnalog   <= 16'h0000;
      padInEnable <= 16'h0000;
    end else begin
      padPullUp   <= puNext;
      padPullDown <= pdNext;
      padAnalog   <= anNext;
      padInEnable <= ieNext;
    end
  end

  // Peripheral inputs
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      altIn <= 96'h0;
    end else begin
      altIn <= altInNext;
    end
  end
endmodule // gpc_port_a

module gpc_pin_mux (
  input  wire [1:0] mode,
  input  wire [1:0] pull,
  input  wire [3:0] sel,
  input  wire       openDrain,
  input  wire       latchBit,
  input  wire [5:0] altOutBits,
  input  wire [5:0] altOeBits,
  input  wire       padBit,
  output reg        outBit,
  output reg        oeBit,
  output reg        puBit,
  output reg        pdBit,
  output reg        anBit,
  output reg        ieBit,
  output reg  [5:0] altInBits
);
  reg         srcData;
  reg         srcOe;
  wire        selOk = (sel <= `GPC_ALT_MAX); // R13
  always @* begin
    srcData   = 1'b0;
    srcOe     = 1'b0;
    altInBits = 6'h00;
    case (mode) // R1
      `GPC_MODE_OUTPUT: begin
        srcData = latchBit; // R5
        srcOe   = 1'b1;
      end
      `GPC_MODE_ALT: begin
        if (selOk) begin
          srcData             = altOutBits[sel[2:0]]; // R5
          srcOe               = altOeBits[sel[2:0]];
          altInBits[sel[2:0]] = padBit; // R6
        end
      end
      default: begin
        srcData = 1'b0;
        srcOe   = 1'b0;
      end
    endcase
  end
  always @* begin
    anBit = (mode == `GPC_MODE_ANALOG); // R9
    ieBit = ~anBit;
    puBit = ~anBit & (pull == `GPC_PULL_UP); // R3
    pdBit = ~anBit & (pull == `GPC_PULL_DOWN); // R3
    if (openDrain) begin
      outBit = 1'b0; // R7
      oeBit  = srcOe & ~srcData; // R7
    end else begin
      outBit = srcData;
      oeBit  = srcOe;
    end
  end
endmodule // gpc_pin_mux

// ---- dv/gpc_port_a_bench.sv ----
`timescale 1ns/1ps
module gpc_port_a_bench;
  reg         clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  reg  [11:0] haddr = 12'h000;
  reg  [1:0]  htrans = 2'b00, m;
  reg  [2:0]  hsize = 3'b010, hburst = 3'b000;
  reg  [31:0] hwdata = 32'h00000000, cfg, pull, d;
  reg  [15:0] padIn = 16'h0000, lat, dt, oe, ou, pu, pd, an, ds = 16'h0000;
  reg  [95:0] altOut = 96'h0, altOe = 96'h0, ai;
  reg  [63:0] asel = 64'h0;
  reg  [3:0]  s;
  wire [31:0] hrdata;
  wire        hreadyout, hresp;
  wire        hready = hreadyout;
  wire [15:0] padOut, padOe, padPullUp, padPullDown, padAnalog, padInEnable, padDriveHigh;
  wire [95:0] altIn;
  integer     err_count = 0, total_checks = 0, cyc = 0, i, k;
  gpc_port_a gpc_port_a_inst (.*);
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      err_count = err_count + 1;
      test_done;
    end
  end
  task test_done;
    begin
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task acc(input [11:0] a, input w, input [2:0] sz, input [31:0] wd, input [31:0] exp);
    begin
      @(negedge clk);
      {haddr, hwrite, hsize, htrans, hsel} = {a, w, sz, 2'b10, 1'b1};
      @(negedge clk);
      {htrans, hsel, hwdata} = {2'b00, 1'b0, wd};
      chk(hrdata & {32{!w}}, exp & {32{!w}});
      chk({hresp, hreadyout}, (sz == 3'b010 && a[1:0] == 2'b00) ? 2'b01 : 2'b10);
      @(negedge clk);
      hsize = 3'b010;
    end
  endtask
  task wr(input [11:0] a, input [31:0] wd); acc(a, 1'b1, 3'b010, wd, 32'h0); endtask
  task rdc(input [11:0] a, input [31:0] e); acc(a, 1'b0, 3'b010, 32'h0, e); endtask
  task pads;
    begin
      ai = 96'h0;
      for (k = 0; k < 16; k = k + 1) begin
        m = cfg[2*k +: 2];
        s = asel[4*k +: 4];
        an[k] = m == 2'b11;
        pu[k] = !an[k] && pull[2*k +: 2] == 2'b01;
        pd[k] = !an[k] && pull[2*k +: 2] == 2'b10;
        ou[k] = m == 2'b01 ? lat[k] : s < 6 && altOut[6*k + s];
        oe[k] = (m == 2'b01 || m == 2'b10 && s < 6 && altOe[6*k + s]) && !(dt[k] && ou[k]);
        ou[k] = ou[k] && !dt[k];
        if (m == 2'b10 && s < 6) ai[6*k + s] = padIn[k];
      end
      repeat (2) @(negedge clk);
      chk(padAnalog, an);
      chk(padInEnable ^ an, 32'h0000ffff);
      chk(padPullUp, pu);
      chk(padPullDown, pd);
      chk(padOe, oe);
      chk(padOut & oe, ou & oe);
      chk(altIn[31:0], ai[31:0]);
      chk(altIn[63:32], ai[63:32]);
      chk(altIn[95:64], ai[95:64]);
      chk(padDriveHigh, ds);
    end
  endtask
  initial begin
    d = $urandom(32'h957ad640);
    {cfg, pull, lat, dt} = {32'hebff0fff, 32'h24005000, 16'h0000, 16'h0000};
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    rdc(12'h000, cfg);
    rdc(12'h008, pull);
    pads;
    rdc(12'h01c, 32'h00000000);
    rdc(12'h030, 32'h00000000);
    for (i = 0; i < 8; i = i + 1) begin
      d = $urandom;
      wr(i[1:0] == 2'b00 ? 12'h010 : 12'h01c + {i[1:0], 2'b00}, d);
      case (i[1:0])
        2'd0: lat = d[15:0];
        2'd1: lat = lat & ~d[15:0];
        2'd2: lat = lat | d[15:0];
        default: lat = lat ^ d[15:0];
      endcase
      rdc(12'h010, {16'h0000, lat});
    end
    for (i = 0; i < 6; i = i + 1) begin
      cfg = $urandom;
      pull = ($urandom & 32'h55555555) << i[0];
      d = $urandom;
      dt = d[15:0];
      {altOut, altOe, padIn} = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
      wr(12'h000, cfg);
      wr(12'h008, pull);
      wr(12'h018, d);
      asel = {$urandom, $urandom};
      ds = asel[47:32] ^ asel[15:0];
      wr(12'h040, asel[31:0]);
      wr(12'h044, asel[63:32]);
      wr(12'h01c, {16'hffff, ds});
      pads;
      rdc(12'h040, asel[31:0]);
      rdc(12'h044, asel[63:32]);
      rdc(12'h018, {16'h0000, dt});
      rdc(12'h014, {16'h0000, padIn});
    end
    acc(12'h010, 1'b1, 3'b000, 32'h0000ffff, 32'h0);
    rdc(12'h010, {16'h0000, lat});
    acc(12'h012, 1'b1, 3'b010, 32'h0000ffff, 32'h0);
    rdc(12'h010, {16'h0000, lat});
    reset_n = 1'b0;
    @(negedge clk);
    reset_n = 1'b1;
    rdc(12'h000, 32'hebff0fff);
    rdc(12'h008, 32'h24005000);
    test_done;
  end
endmodule // gpc_port_a_bench

// ---- dv/gpc_port_a_checker.sv ----
`timescale 1ns/1ps
module gpc_port_a_checker (
  input wire        clk,
  input wire        reset_n,
  input wire        hsel,
  input wire [11:0] haddr,
  input wire [1:0]  htrans,
  input wire [2:0]  hsize,
  input wire [2:0]  hburst,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire [15:0] padOe,
  input wire [15:0] padPullUp,
  input wire [15:0] padPullDown,
  input wire [15:0] padAnalog,
  input wire [15:0] padInEnable
);
  wire take = hsel && hready && htrans == 2'b10;
  wire legal = hsize == 3'b010 && hburst == 3'b000 && haddr[1:0] == 2'b00;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_err_shape: assert property (take && !legal |=> hresp && !hreadyout ##1 hresp && hreadyout)
    else $error("bad error reply");
  a_ok_reply: assert property (take && legal |=> !hresp && hreadyout)
    else $error("bad okay reply");
  a_wait_err: assert property (!hreadyout |-> hresp)
    else $error("stall without error");
  a_rdata_hold: assert property (!take |=> $stable(hrdata))
    else $error("read data moved");
  a_input_buf: assert property ($past(reset_n) |-> padInEnable == ~padAnalog)
    else $error("input buffer wrong");
  a_analog_pull: assert property ((padAnalog & (padPullUp | padPullDown)) == 16'h0000)
    else $error("pull on analog pin");
  a_pull_excl: assert property ((padPullUp & padPullDown) == 16'h0000)
    else $error("both pulls on");
  a_analog_float: assert property ((padAnalog & padOe) == 16'h0000)
    else $error("analog pin driven");
endmodule // gpc_port_a_checker
bind gpc_port_a gpc_port_a_checker gpc_port_a_checker_inst (.*);
